// File: hw/xpt_bus_master.sv
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module xpt_bus_master (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  xpt_link_if.master link,
  output logic o_switch_rst_b
);
  import xpt_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_DONE} mst_state_t;

  ////////////////////////////////////////////////////////////////////
  // register file
  mst_state_t state_q;
  logic [15:0] cmd_q;
  logic [2:0] strap_q;
  logic [7:0] div_q;
  logic nack_q;
  logic rst_b_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic go_q;

  wire busy = state_q != M_IDLE;
  wire acc = i_avs_read | i_avs_write;
  // write of the command register stalls while a frame runs; strap writes then are dropped, so reset keeps its value
  wire hold = i_avs_write && i_avs_address == REG_CMD && busy;
  // writes commit at the edge where waitrequest is low, as the master sees it
  wire wr_cmd = i_avs_write && i_avs_address == REG_CMD && !busy && !wait_q && !go_q;
  wire [31:0] rd_mux = i_avs_address == REG_CMD ? {16'h0, cmd_q}
                     : i_avs_address == REG_STATUS ? {30'h0, nack_q, busy}
                     : i_avs_address == REG_STRAP ? {28'h0, rst_b_q, strap_q}
                     : i_avs_address == REG_DIV ? {24'h0, div_q} : 32'h0;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      cmd_q <= 16'h0;
      strap_q <= 3'h0;
      div_q <= 8'(CLK_DIV_RESET);
      rst_b_q <= 1'b1;
      go_q <= 1'b0;
    end else begin
      go_q <= wr_cmd;
      // one wait cycle per access, then release for one cycle
      wait_q <= !(acc && wait_q && !hold);
      if (acc && wait_q && i_avs_read) begin
        rdata_q <= rd_mux;
      end
      if (wr_cmd) begin
        cmd_q <= i_avs_writedata[15:0];
      end
      if (i_avs_write && !wait_q && !busy && i_avs_address == REG_STRAP) begin
        strap_q <= i_avs_writedata[2:0];
        rst_b_q <= i_avs_writedata[3];
      end
      if (i_avs_write && !wait_q && !busy && i_avs_address == REG_DIV && i_avs_writedata[7:0] != 8'h0) begin
        div_q <= i_avs_writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link engine: quarter phases per bit
  logic [7:0] tick_q;
  logic [1:0] ph_q;
  logic [4:0] bit_q;
  logic [1:0] byte_q;
  logic [23:0] frame_q;
  logic scl_q, sda_q;
  logic [1:0] sda_in_q;
  wire tick = tick_q == div_q - 8'h1;
  wire bit_ack = bit_q == 5'd8;

  always_ff @(posedge i_clk) begin
    sda_in_q <= {sda_in_q[0], link.sda};
    if (!i_rst_b) begin
      state_q <= M_IDLE;
      tick_q <= 8'h0;
      ph_q <= 2'h0;
      bit_q <= 5'h0;
      byte_q <= 2'h0;
      frame_q <= 24'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nack_q <= 1'b0;
    end else begin
      tick_q <= (tick || state_q == M_IDLE) ? 8'h0 : tick_q + 8'h1;
      case (state_q)
        M_IDLE: begin
          if (go_q) begin
            frame_q <= {BUS_ADDR_HI, strap_q, 1'b0, cmd_q};
            nack_q <= 1'b0;
            state_q <= M_START;
          end
        end
        M_START: begin
          if (tick) begin
            sda_q <= 1'b0;
            state_q <= M_BIT;
            ph_q <= 2'h0;
            bit_q <= 5'h0;
            byte_q <= 2'h0;
          end
        end
        M_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: scl_q <= 1'b0;
              2'h1: begin
                sda_q <= bit_ack ? 1'b1 : frame_q[23];
              end
              2'h2: scl_q <= 1'b1;
              default: begin
                if (bit_ack) begin
                  if (sda_in_q[1]) begin
                    nack_q <= 1'b1;
                  end
                  bit_q <= 5'h0;
                  byte_q <= byte_q + 2'h1;
                  if (byte_q == 2'h2 || sda_in_q[1]) begin
                    state_q <= M_STOP;
                  end
                end else begin
                  frame_q <= {frame_q[22:0], 1'b0};
                  bit_q <= bit_q + 5'h1;
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: scl_q <= 1'b0;
              2'h1: sda_q <= 1'b0;
              2'h2: scl_q <= 1'b1;
              default: begin
                sda_q <= 1'b1;
                state_q <= M_DONE;
              end
            endcase
          end
        end
        M_DONE: state_q <= M_IDLE;
        default: state_q <= M_IDLE;
      endcase
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_switch_rst_b = rst_b_q;
  assign link.scl_o = scl_q;
  assign link.scl_oe = ~scl_q;
  assign link.sda_m_o = sda_q;
  assign link.sda_m_oe = ~sda_q;
endmodule
`default_nettype wire

// File: hw/xpt_pkg.sv
package xpt_pkg;
  localparam int NUM_ROWS = 10;
  localparam int NUM_COLS = 8;
  localparam int NUM_SW = NUM_ROWS * NUM_COLS;
  // seven-bit bus address, upper four bits fixed
  localparam logic [3:0] BUS_ADDR_HI = 4'he;
  // 24-bit command word layout
  localparam int CMD_W = 24;
  localparam int DIR_POS = 16;
  localparam int DATA_POS = 15;
  localparam int ROW_HI = 14;
  localparam int ROW_LO = 11;
  localparam int COL_HI = 10;
  localparam int COL_LO = 8;
  localparam int UPD_POS = 0;
  // row select codes
  localparam logic [3:0] ROW_CODE_X0 = 4'h2;
  localparam logic [3:0] ROW_CODE_X3 = 4'h5;
  localparam logic [3:0] ROW_CODE_X4 = 4'h8;
  localparam logic [3:0] ROW_CODE_X9 = 4'hd;
  localparam logic [NUM_SW-1:0] SW_RESET = '0;
  // avalon register offsets of the master controller (byte addresses)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_STRAP = 4'h8;
  localparam logic [3:0] REG_DIV = 4'hc;
  // link clock quarter period in system cycles, 40 MHz / (4*20) = 500 kHz
  localparam int CLK_DIV_RESET = 20;
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_NACK = 1;
endpackage

// File: hw/xpt_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface xpt_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // open drain: line is low whenever an enabled driver drives low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// File: hw/xpt_switch_slave.sv
// What this block does
// - slave only, never drives clock line
// - address is 1110 plus strap pins
// - start is sda falling, scl high
// - shift seven address bits then direction
// - acknowledge matching write address on ninth pulse
// - mismatch: stay silent until next start
// - direction bit one is ignored, zero writes
// - nine pulses per byte, receiver acknowledges
// - data changes only while clock low
// - stop is sda rising, scl high
// - write ends with stop after 27th pulse
// - three-byte write fills 24-bit register
// - data bit one closes, zero opens
// - row and column fields pick switch
// - row codes 2-5 and 8-d, others none
// - column code is plain binary index
// - update bit applies pending settings
// - reset pin high during writes
// - supports only bus rates slow enough for 40 MHz sampling, not 3.4 MHz
// - write changes only the named switch's pending setting
// - reset low opens and clears all
// - power-up opens all, registers zero
`timescale 1ns/1ps
`default_nettype none
module xpt_switch_slave (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_addr_strap_bit0,
  input wire logic i_addr_strap_bit1,
  input wire logic i_addr_strap_bit2,
  input wire logic i_switch_rst_b,
  xpt_link_if.device link,
  output logic [xpt_pkg::NUM_SW-1:0] o_switch_on
);
  import xpt_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_BITS, S_ACK, S_IGNORE} slv_state_t;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers; at 40 MHz the 3.4 MHz rate is out of reach, so only bus timing slow enough is served
  logic [1:0] scl_sync_q, sda_sync_q, rst_sync_q;
  logic [2:0] strap_s1_q, strap_s2_q;
  logic scl_q, sda_q;
  always_ff @(posedge i_clk) begin
    scl_sync_q <= {scl_sync_q[0], link.scl};
    sda_sync_q <= {sda_sync_q[0], link.sda};
    rst_sync_q <= {rst_sync_q[0], i_switch_rst_b};
    strap_s1_q <= {i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0};
    strap_s2_q <= strap_s1_q;
    scl_q <= scl_sync_q[1];
    sda_q <= sda_sync_q[1];
  end

  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det = scl_s & scl_q & ~sda_q & sda_s;
  wire pin_rst = ~rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////
  slv_state_t state_q, state_d;
  logic [CMD_W-1:0] shift_q, shift_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [1:0] byte_cnt_q, byte_cnt_d;
  logic ack_drv_q, ack_drv_d;
  logic word_done_q, word_done_d;
  logic [NUM_SW-1:0] pend_q, live_q;

  wire [6:0] own_addr = {BUS_ADDR_HI, strap_s2_q};
  wire [7:0] byte_in = {shift_q[6:0], sda_s};
  wire addr_match = byte_in[7:1] == own_addr;
  wire dir_read = byte_in[0];

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    byte_cnt_d = byte_cnt_q;
    ack_drv_d = ack_drv_q;
    word_done_d = 1'b0;
    if (start_det) begin
      state_d = S_BITS;
      bit_cnt_d = 4'h0;
      byte_cnt_d = 2'h0;
      ack_drv_d = 1'b0;
    end else if (stop_det) begin
      state_d = S_IDLE;
      ack_drv_d = 1'b0;
    end else begin
      case (state_q)
        S_BITS: begin
          if (scl_rise) begin
            shift_d = {shift_q[CMD_W-2:0], sda_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) begin
              if (byte_cnt_q == 2'h0 && (!addr_match || dir_read)) begin
                state_d = S_IGNORE;
              end else begin
                state_d = S_ACK;
              end
            end
          end
        end
        S_ACK: begin
          // drive ack from the falling edge after the eighth bit
          if (scl_fall && !ack_drv_q) begin
            ack_drv_d = 1'b1;
          end else if (scl_fall && ack_drv_q) begin
            ack_drv_d = 1'b0;
            bit_cnt_d = 4'h0;
            byte_cnt_d = byte_cnt_q + 2'h1;
            if (byte_cnt_q == 2'h2) begin
              word_done_d = 1'b1;
              state_d = S_IGNORE;
            end else begin
              state_d = S_BITS;
            end
          end
        end
        S_IGNORE: state_d = S_IGNORE;
        S_IDLE: state_d = S_IDLE;
        default: state_d = S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decode of the latched command word
  wire [3:0] row_line_select = shift_q[ROW_HI:ROW_LO];
  wire [2:0] column_line_select = shift_q[COL_HI:COL_LO];
  wire row_lo_ok = row_line_select >= ROW_CODE_X0 && row_line_select <= ROW_CODE_X3;
  wire row_hi_ok = row_line_select >= ROW_CODE_X4 && row_line_select <= ROW_CODE_X9;
  wire [3:0] row_idx = row_lo_ok ? row_line_select - ROW_CODE_X0
                     : row_line_select - ROW_CODE_X4 + 4'h4;
  wire row_ok = row_lo_ok | row_hi_ok;
  wire [6:0] sw_idx = 7'(row_idx) * 7'(NUM_COLS) + 7'(column_line_select);
  wire switch_update_strobe = shift_q[UPD_POS];
  wire sw_data = shift_q[DATA_POS];

  logic [NUM_SW-1:0] pend_d;
  always_comb begin
    pend_d = pend_q;
    if (row_ok) begin
      pend_d[sw_idx] = sw_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || pin_rst) begin
      state_q <= S_IDLE;
      shift_q <= '0;
      bit_cnt_q <= 4'h0;
      byte_cnt_q <= 2'h0;
      ack_drv_q <= 1'b0;
      word_done_q <= 1'b0;
      pend_q <= SW_RESET;
      live_q <= SW_RESET;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      byte_cnt_q <= byte_cnt_d;
      ack_drv_q <= ack_drv_d;
      word_done_q <= word_done_d;
      if (word_done_q) begin
        pend_q <= pend_d;
        if (switch_update_strobe) begin
          live_q <= pend_d;
        end
      end
    end
  end

  // only sda is ever driven; clock line is input only
  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = ack_drv_q;
  assign o_switch_on = live_q;
endmodule
`default_nettype wire

// File: sim/xpt_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module xpt_link_checker (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  wire start_w;
  wire rise_w;
  //////////////////////////////////////////////////////////////////
  // bit counter restarts on every start, wraps after the ack pulse
  assign start_w = scl && scl_q && sda_q && !sda;
  assign rise_w = scl && !scl_q;
  assign cnt_d = start_w ? 4'h0 : !rise_w ? cnt_q : (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
  always_ff @(posedge i_clk) begin
    scl_q <= !i_rst_b | scl;
    sda_q <= !i_rst_b | sda;
    cnt_q <= i_rst_b ? cnt_d : 4'h0;
  end
  //////////////////////////////////////////////////////////////////
  sequence start_s;
    $fell(sda) && scl;
  endsequence
  sequence stop_s;
    $rose(sda) && scl;
  endsequence
  sequence ack_s;
    $rose(sda_s_oe);
  endsequence
  a_ack_pulls_low: assert property (sda_s_oe |-> !sda_s_o) else $error("slave drove sda high");
  a_edge_in_low: assert property ($changed(sda_s_oe) |-> !scl) else $error("slave sda moved in high");
  a_ack_after_eight: assert property (ack_s |-> cnt_q == 4'h8) else $error("ack not after bit 8");
  a_ack_holds: assert property (ack_s |-> sda_s_oe [*8]) else $error("ack too short");
  a_ack_bounded: assert property (ack_s |-> ##[1:400] !sda_s_oe) else $error("ack never released");
  a_ack_ninth: assert property (sda_s_oe && rise_w |-> cnt_q == 4'h8) else $error("ack on wrong pulse");
  a_quiet_start: assert property (start_s |-> !sda_s_oe [*8]) else $error("slave drove after start");
  a_stop_free: assert property (stop_s |-> !sda_s_oe) else $error("slave drove at stop");
endmodule
`default_nettype wire

// File: sim/test_crosspoint_i2c_switch_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_crosspoint_i2c_switch_ctrl;
  import xpt_pkg::*;
  logic i_clk;
  logic i_rst_b;
  logic [2:0] strap;
  logic [3:0] av_a;
  logic av_rd;
  logic av_wr;
  logic [31:0] av_wd;
  logic [31:0] av_q;
  logic av_wait;
  logic sw_rst_b;
  logic [NUM_SW-1:0] sw_on;
  logic [NUM_SW-1:0] exp_sw;
  logic [31:0] q;
  int bad_count;
  int num_checks;
  // switch index expected for each row code; column is {c0,c3,c1}
  int exp_idx [16] = '{-1, -1, 1, 13, 16, 28, -1, -1, 34, 46, 51, 63, 66, 78, -1, -1};
  xpt_link_if link();
  xpt_switch_slave u_xpt_switch_slave (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr_strap_bit0(strap[0]),
    .i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]), .i_switch_rst_b(sw_rst_b),
    .link(link.device), .o_switch_on(sw_on));
  xpt_bus_master u_xpt_bus_master (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(av_a), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wd), .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait),
    .link(link.master), .o_switch_rst_b(sw_rst_b));
  xpt_link_checker u_xpt_link_checker (.i_clk(i_clk), .i_rst_b(i_rst_b), .scl(link.scl), .sda(link.sda),
    .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe));
  //////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [NUM_SW-1:0] got, input logic [NUM_SW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic rd, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    av_a <= a;
    av_rd <= rd;
    av_wr <= !rd;
    av_wd <= d;
    @(posedge i_clk);
    while (av_wait !== 1'b0 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    q = av_q;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    if (n == 50) bad_count++;
  endtask
  // one full write frame, then poll until the master goes idle
  task automatic frame(input logic [15:0] cmd);
    int n;
    n = 0;
    bus(REG_CMD, 1'b0, {16'h0, cmd});
    q = 32'h1;
    while (q[STATUS_BUSY] !== 1'b0 && n < 2000) begin
      bus(REG_STATUS, 1'b1, 32'h0);
      n++;
    end
    if (n == 2000) bad_count++;
    repeat (8) @(posedge i_clk);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    bad_count++;
    conclude();
  end
  initial begin
    i_rst_b = 1'b0;
    strap = 3'h5;
    av_a = 4'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0;
    bad_count = 0;
    num_checks = 0;
    exp_sw = '0;
    repeat (10) @(posedge i_clk);
    chk(sw_on, '0);
    i_rst_b <= 1'b1;
    bus(REG_STRAP, 1'b0, 32'hd);
    bus(REG_DIV, 1'b0, 32'ha);
    bus(REG_DIV, 1'b0, 32'h0);
    bus(REG_DIV, 1'b1, 32'h0);
    chk({48'h0, q}, 80'ha);
    bus(4'h2, 1'b1, 32'h0);
    chk({48'h0, q}, 80'h0);
    for (int c = 0; c < 16; c++) begin
      frame({1'b1, 4'(c), 1'(c), 1'(c >> 3), 1'(c >> 1), 8'h01});
      if (exp_idx[c] >= 0) exp_sw[exp_idx[c]] = 1'b1;
      chk(sw_on, exp_sw);
    end
    // latched words leave the array alone until an update word
    frame(16'h1100);
    chk(sw_on, exp_sw);
    frame(16'h1d00);
    chk(sw_on, exp_sw);
    frame(16'h0001);
    exp_sw[1] = 1'b0;
    exp_sw[13] = 1'b0;
    chk(sw_on, exp_sw);
    strap <= 3'h3;
    bus(REG_STRAP, 1'b0, 32'hb);
    frame(16'h9001);
    exp_sw[0] = 1'b1;
    chk(sw_on, exp_sw);
    chk({79'h0, q[STATUS_NACK]}, 80'h0);
    bus(REG_STRAP, 1'b0, 32'hd);
    frame(16'h9801);
    chk(sw_on, exp_sw);
    chk({79'h0, q[STATUS_NACK]}, 80'h1);
    // switch reset pin also clears what is still pending
    bus(REG_STRAP, 1'b0, 32'h3);
    repeat (6) @(posedge i_clk);
    chk(sw_on, '0);
    bus(REG_STRAP, 1'b0, 32'hb);
    frame(16'h0001);
    chk(sw_on, '0);
    conclude();
  end
endmodule
`default_nettype wire
